// ==== mrio_cfg.svh ====
`ifndef MRIO_CFG_SVH
`define MRIO_CFG_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define MRIO_ADDR_W 8
`define MRIO_OFF_CTRL 8'h00
`define MRIO_OFF_STATUS 8'h04
`define MRIO_OFF_PORT 8'h08
`define MRIO_OFF_IDENT 8'h0C
`define MRIO_CTRL_RST 32'h00000001
`define MRIO_CTRL_BUS_EN 0
`define MRIO_RESP_OKAY 2'h0
`define MRIO_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// pin sampler: bit positions and idle (pin-high) levels
// ----------------------------------------------------------------------
`define MRIO_PIN_W 13
`define MRIO_PIN_IO 0
`define MRIO_PIN_DATA 4
`define MRIO_PIN_PH1 8
`define MRIO_PIN_PH2 9
`define MRIO_PIN_SYNC 10
`define MRIO_PIN_ROMSEL 11
`define MRIO_PIN_DRES 12
`define MRIO_PIN_IDLE 13'h1FFF

// ----------------------------------------------------------------------
// instruction nibbles of the port commands
// ----------------------------------------------------------------------
`define MRIO_OPR_IO 4'hE
`define MRIO_OPA_WRITE 4'h2
`define MRIO_OPA_READ 4'hA

`endif

// ==== mrio_pkg.sv ====
package mrio_pkg;

    // bus slots of one instruction cycle; idle until the first sync
    typedef enum logic [3:0] {
        SL_IDLE,
        SL_A1,
        SL_A2,
        SL_A3,
        SL_M1,
        SL_M2,
        SL_X1,
        SL_X2,
        SL_X3
    } mrio_slot_e;

    typedef logic [3:0] mrio_nib_t;

endpackage : mrio_pkg

// ==== mrio_top.sv ====
`timescale 1ns/1ps
`include "mrio_cfg.svh"

module mrio_top #(
    parameter logic [3:0] CHIP_ID = 4'h0,
    parameter logic [3:0] IO_DIR_OUT = 4'h0,
    parameter logic [3:0] IO_INV = 4'h0,
    parameter logic [3:0] IO_OUT_RDVAL = 4'h0,
    parameter logic [2047:0] ROM_IMAGE = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic phase1_n_i,
    input wire logic phase2_n_i,
    input wire logic sync_n_i,
    input wire logic rom_command_select_n_i,
    input wire logic dev_reset_n_i,
    input wire logic port_clear_n_i,
    input wire logic [3:0] data_in_i,
    output logic [3:0] data_out_o,
    output logic [3:0] data_oe_n_o,
    input wire logic [3:0] io_in_i,
    output logic [3:0] io_out_o,
    output logic [3:0] io_oe_n_o,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [`MRIO_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [`MRIO_ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o
);

    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    // every pin passes three flops; the filtered level moves only when
    // the second and third stage agree. not cleared by the device reset
    // pin, only by the power-on reset.
    wire logic [`MRIO_PIN_W-1:0] pins;
    logic [`MRIO_PIN_W-1:0] s1_q;
    logic [`MRIO_PIN_W-1:0] s2_q;
    logic [`MRIO_PIN_W-1:0] s3_q;
    logic [`MRIO_PIN_W-1:0] flt_q;

    assign pins = {dev_reset_n_i, rom_command_select_n_i, sync_n_i,
                   phase2_n_i, phase1_n_i, data_in_i, io_in_i};

    for (genvar gi = 0; gi < `MRIO_PIN_W; gi++) begin : g_sync
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                s1_q[gi] <= 1'b1;
                s2_q[gi] <= 1'b1;
                s3_q[gi] <= 1'b1;
                flt_q[gi] <= 1'b1;
            end else begin
                s1_q[gi] <= pins[gi];
                s2_q[gi] <= s1_q[gi];
                s3_q[gi] <= s2_q[gi];
                if (s2_q[gi] == s3_q[gi]) begin
                    flt_q[gi] <= s3_q[gi];
                end
            end
        end
    end

    // negative logic: a low pin level is a logic one
    wire logic ph1 = ~flt_q[`MRIO_PIN_PH1];
    wire logic ph2 = ~flt_q[`MRIO_PIN_PH2];
    wire logic sync_act = ~flt_q[`MRIO_PIN_SYNC];
    wire logic rom_sel = ~flt_q[`MRIO_PIN_ROMSEL];
    wire logic dres = ~flt_q[`MRIO_PIN_DRES];
    wire mrio_pkg::mrio_nib_t bus_nib = ~flt_q[`MRIO_PIN_DATA +: 4];
    // pin to logic per option: non-inverting inputs are negative logic
    wire logic [3:0] io_lg = flt_q[`MRIO_PIN_IO +: 4] ^ ~IO_INV;

    // ------------------------------------------------------------------
    // slot timing from the processor clocks
    // ------------------------------------------------------------------
    logic ph1_prev_q;
    logic ph2_prev_q;
    logic sync_pend_q;
    mrio_pkg::mrio_slot_e slot_q;
    mrio_pkg::mrio_slot_e slot_d;

    wire logic ph1_ev = ph1 & ~ph1_prev_q;
    wire logic ph2_ev = ph2 & ~ph2_prev_q;

    // a cycle runs A1..X3; sync seen at phase two restarts at A1
    always_comb begin
        case (slot_q)
            mrio_pkg::SL_A1: slot_d = mrio_pkg::SL_A2;
            mrio_pkg::SL_A2: slot_d = mrio_pkg::SL_A3;
            mrio_pkg::SL_A3: slot_d = mrio_pkg::SL_M1;
            mrio_pkg::SL_M1: slot_d = mrio_pkg::SL_M2;
            mrio_pkg::SL_M2: slot_d = mrio_pkg::SL_X1;
            mrio_pkg::SL_X1: slot_d = mrio_pkg::SL_X2;
            mrio_pkg::SL_X2: slot_d = mrio_pkg::SL_X3;
            mrio_pkg::SL_X3: slot_d = mrio_pkg::SL_A1;
            default: slot_d = mrio_pkg::SL_IDLE;
        endcase
        if (sync_pend_q) begin
            slot_d = mrio_pkg::SL_A1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph1_prev_q <= 1'b0;
            ph2_prev_q <= 1'b0;
        end else begin
            ph1_prev_q <= ph1;
            ph2_prev_q <= ph2;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_q <= mrio_pkg::SL_IDLE;
            sync_pend_q <= 1'b0;
        end else if (dres) begin
            slot_q <= mrio_pkg::SL_IDLE;
            sync_pend_q <= 1'b0;
        end else if (ph1_ev) begin
            slot_q <= slot_d;
            sync_pend_q <= 1'b0;
        end else if (ph2_ev && sync_act) begin
            sync_pend_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // address, chip match and command capture at phase two
    // ------------------------------------------------------------------
    wire logic cap_a1 = ph2_ev && slot_q == mrio_pkg::SL_A1;
    wire logic cap_a2 = ph2_ev && slot_q == mrio_pkg::SL_A2;
    wire logic cap_a3 = ph2_ev && slot_q == mrio_pkg::SL_A3;
    wire logic cap_m1 = ph2_ev && slot_q == mrio_pkg::SL_M1;
    wire logic cap_m2 = ph2_ev && slot_q == mrio_pkg::SL_M2;
    wire logic cap_x2 = ph2_ev && slot_q == mrio_pkg::SL_X2;

    logic [7:0] addr_q;
    logic rom_hit_q;
    mrio_pkg::mrio_nib_t opr_q;
    logic wr_pend_q;
    logic rd_pend_q;
    mrio_pkg::mrio_nib_t chip_sel_q;

    // only a chip number sent with rom select may match
    wire logic id_match = rom_sel && bus_nib == CHIP_ID;
    wire logic io_instr = rom_sel && opr_q == `MRIO_OPR_IO;
    wire logic sel_match = chip_sel_q == CHIP_ID;
    wire logic port_wr = cap_x2 && wr_pend_q && sel_match;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_q <= 8'h00;
            rom_hit_q <= 1'b0;
            opr_q <= 4'h0;
        end else if (dres) begin
            addr_q <= 8'h00;
            rom_hit_q <= 1'b0;
            opr_q <= 4'h0;
        end else begin
            if (cap_a1) begin
                addr_q[3:0] <= bus_nib;
            end
            if (cap_a2) begin
                addr_q[7:4] <= bus_nib;
            end
            if (cap_a3) begin
                rom_hit_q <= id_match;
            end
            if (cap_m1) begin
                opr_q <= bus_nib;
            end
        end
    end

    // port commands ride the memory slots flagged by rom select in M2;
    // the ram select of a register select is not needed here
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else if (dres || cap_a1) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else if (cap_m2) begin
            wr_pend_q <= io_instr && bus_nib == `MRIO_OPA_WRITE;
            rd_pend_q <= io_instr && bus_nib == `MRIO_OPA_READ;
        end
    end

    // selection taken in X2 with rom select, X3 nibble ignored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_sel_q <= 4'h0;
        end else if (dres) begin
            chip_sel_q <= 4'h0;
        end else if (cap_x2 && rom_sel) begin
            chip_sel_q <= bus_nib;
        end
    end

    // ------------------------------------------------------------------
    // output port latches
    // ------------------------------------------------------------------
    // port clear is asynchronous and unsynchronised by design; a glitch
    // on it empties the latches, which is the documented behaviour
    logic [3:0] port_q;

    always_ff @(posedge clk_i or negedge rst_n_i or negedge port_clear_n_i)
    begin
        if (!rst_n_i || !port_clear_n_i) begin
            port_q <= 4'h0;
        end else if (dres) begin
            port_q <= 4'h0;
        end else if (port_wr) begin
            // bit 0 of the working register lands on pin 0
            port_q <= bus_nib & IO_DIR_OUT;
        end
    end

    assign io_out_o = (port_q ^ ~IO_INV) & IO_DIR_OUT;
    assign io_oe_n_o = ~IO_DIR_OUT;

    // ------------------------------------------------------------------
    // rom array and bus drive
    // ------------------------------------------------------------------
    wire logic [7:0] rom_mem [256];

    for (genvar gr = 0; gr < 256; gr++) begin : g_rom
        assign rom_mem[gr] = ROM_IMAGE[gr*8 +: 8];
    end

    logic [31:0] ctrl_q;
    logic drv_q;
    mrio_pkg::mrio_nib_t dout_q;

    wire logic [7:0] rom_word = rom_mem[addr_q];
    // output pins read back their fixed value
    wire logic [3:0] port_rd = (io_lg & ~IO_DIR_OUT) |
                               (IO_OUT_RDVAL & IO_DIR_OUT);
    wire logic bus_en = ctrl_q[`MRIO_CTRL_BUS_EN];
    wire logic drv_rom = rom_hit_q &&
        (slot_d == mrio_pkg::SL_M1 || slot_d == mrio_pkg::SL_M2);
    wire logic drv_rd = rd_pend_q && sel_match &&
        slot_d == mrio_pkg::SL_X2;
    // upper half in M1, lower half in M2
    wire mrio_pkg::mrio_nib_t dout_d =
        drv_rd ? port_rd :
        (slot_d == mrio_pkg::SL_M1) ? rom_word[7:4] : rom_word[3:0];

    // drive is decided on entry to each slot and held until the next one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_q <= 1'b0;
            dout_q <= 4'h0;
        end else if (dres) begin
            drv_q <= 1'b0;
            dout_q <= 4'h0;
        end else if (ph1_ev) begin
            drv_q <= bus_en && (drv_rom || drv_rd);
            dout_q <= dout_d;
        end
    end

    assign data_out_o = ~dout_q;
    assign data_oe_n_o = {4{~drv_q}};

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    logic aw_got_q;
    logic w_got_q;
    logic [`MRIO_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_awready_o = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready_o = ~w_got_q & ~bvalid_q;
    assign s_axi_arready_o = ~rvalid_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;

    wire logic do_wr = aw_got_q && w_got_q && !bvalid_q;
    wire logic wr_ctrl = awaddr_q == `MRIO_OFF_CTRL;
    wire logic [31:0] ctrl_d = wdata_q[`MRIO_CTRL_BUS_EN] ? 32'h00000001
                                                          : 32'h00000000;
    wire logic wr_ok = wr_ctrl || awaddr_q == `MRIO_OFF_STATUS ||
        awaddr_q == `MRIO_OFF_PORT || awaddr_q == `MRIO_OFF_IDENT;
    wire logic rd_ack = s_axi_arvalid_i && !rvalid_q;

    wire logic [31:0] st_word = {20'h00000, slot_q, rom_hit_q, wr_pend_q,
                                 rd_pend_q, sel_match, chip_sel_q};
    wire logic [31:0] port_word = {20'h00000, port_rd, io_lg, port_q};
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        if (s_axi_araddr_i == `MRIO_OFF_CTRL) begin
            rd_word = ctrl_q;
        end else if (s_axi_araddr_i == `MRIO_OFF_STATUS) begin
            rd_word = st_word;
        end else if (s_axi_araddr_i == `MRIO_OFF_PORT) begin
            rd_word = port_word;
        end else if (s_axi_araddr_i == `MRIO_OFF_IDENT) begin
            rd_word = {28'h0000000, CHIP_ID};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
        end else if (do_wr) begin
            aw_got_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_got_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
        end else if (do_wr) begin
            w_got_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= `MRIO_RESP_OKAY;
            ctrl_q <= `MRIO_CTRL_RST;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? `MRIO_RESP_OKAY : `MRIO_RESP_SLVERR;
            if (wr_ctrl && wstrb_q[0]) begin
                ctrl_q <= ctrl_d;
            end
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `MRIO_RESP_OKAY;
        end else if (rd_ack) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `MRIO_RESP_OKAY : `MRIO_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wire logic drv_slot = slot_q == mrio_pkg::SL_M1 ||
        slot_q == mrio_pkg::SL_M2 || slot_q == mrio_pkg::SL_X2;

    a_bus_drive_slots: assert property (
        drv_q |-> drv_slot)
        else $error("bus driven outside an own slot");

    a_rom_drive_hit: assert property (
        drv_q && slot_q != mrio_pkg::SL_X2 |-> rom_hit_q)
        else $error("rom data driven without chip match");

    a_rom_word_data: assert property (
        $rose(drv_q) && slot_q == mrio_pkg::SL_M1 |->
        data_out_o == ~rom_mem[addr_q][7:4])
        else $error("memory slot one data is not the upper half");

    a_chip_sel_latch: assert property (
        cap_x2 && rom_sel && !dres |=> chip_sel_q == $past(bus_nib))
        else $error("register select nibble not latched");

    a_port_hold: assert property (
        !port_wr && !dres && port_clear_n_i |=> port_q == $past(port_q)
        || !port_clear_n_i)
        else $error("port latch changed without a write");

    a_input_float: assert property (
        (io_oe_n_o & ~IO_DIR_OUT) == ~IO_DIR_OUT &&
        (port_q & ~IO_DIR_OUT) == 4'h0)
        else $error("input pin driven or latched");

    a_port_clear: assert property (
        !port_clear_n_i |-> port_q == 4'h0)
        else $error("port clear did not empty the latches");

    a_dev_reset: assert property (
        dres |=> chip_sel_q == 4'h0 && !drv_q && port_q == 4'h0 &&
        slot_q == mrio_pkg::SL_IDLE)
        else $error("device reset left state behind");

    a_read_drive: assert property (
        ph1_ev && drv_rd && bus_en && !dres |=>
        drv_q && dout_q == $past(port_rd))
        else $error("port read not driven in execute slot two");

    a_write_resp: assert property (
        do_wr |=> bvalid_q)
        else $error("write response missing");

    c_rom_read: cover property ($rose(drv_q) && slot_q == mrio_pkg::SL_M1);
    c_port_write: cover property (port_wr);
    c_port_read: cover property ($rose(drv_q) && slot_q == mrio_pkg::SL_X2);
    c_chip_select: cover property (cap_x2 && rom_sel && id_match);

endmodule : mrio_top

// ==== mrio_cpu_model.sv ====
`timescale 1ns/1ps

module mrio_cpu_model (
    input wire logic clk_i,
    input wire logic [3:0] dut_out_i,
    input wire logic [3:0] dut_oe_n_i,
    output logic ph1_n_o,
    output logic ph2_n_o,
    output logic sync_n_o,
    output logic rsel_n_o,
    output logic [3:0] bus_o
);
    logic [3:0] drv_q;
    logic oe_n_q;
    logic [3:0] last_q;

    initial begin
        {ph1_n_o, ph2_n_o, sync_n_o, rsel_n_o, oe_n_q} = 5'h1F;
        drv_q = 4'h0;
        last_q = 4'h0;
    end

    // ------
    // shared bus wire
    // ------
    // released lines settle to the inverse of the last driven level, so a
    // stale level never passes for data; a toggling line would not get
    // through the pin filter and would look stale
    always @(posedge clk_i) begin
        if (dut_oe_n_i != 4'hF || !oe_n_q) begin
            last_q <= bus_o;
        end
    end
    assign bus_o = (~dut_oe_n_i & dut_out_i)
        | (dut_oe_n_i & (oe_n_q ? ~last_q : drv_q));

    // each phase level is held 6 clocks, longer than the pin filter
    task automatic slot(input logic [3:0] n, input logic en, input logic sel,
        input logic syn, output logic [3:0] seen, output logic drv);
        ph1_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        ph1_n_o <= 1'b1;
        drv_q <= ~n;
        oe_n_q <= ~en;
        rsel_n_o <= ~sel;
        sync_n_o <= ~syn;
        repeat (2) @(posedge clk_i);
        ph2_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        seen = ~bus_o;
        drv = (dut_oe_n_i !== 4'hF);
        ph2_n_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        {rsel_n_o, sync_n_o, oe_n_q} <= 3'h7;
    endtask : slot

    // ctl: memory-slot drive, rom select in M2, X2 drive, rom select in X2
    task automatic cycle(input logic [7:0] a, input logic [4:0] chip,
        input logic [7:0] ins, input logic [3:0] ctl, input logic [3:0] x2,
        output logic [7:0] word, output logic [3:0] xs, output logic [7:0] dv);
        logic [3:0] s [8];
        logic [3:0] n [8];
        logic [7:0] en;
        logic [7:0] sl;
        n = '{a[3:0], a[7:4], chip[3:0], ins[7:4], ins[3:0], 4'h0, x2, 4'h9};
        en = {1'b1, ctl[1], 1'b1, ctl[3], ctl[3], 3'h7};
        sl = {1'b0, ctl[0], 1'b0, ctl[2], 1'b0, chip[4], 2'h0};
        for (int i = 0; i < 8; i++) begin
            slot(n[i], en[i], sl[i], i == 7, s[i], dv[i]);
        end
        word = {s[3], s[4]};
        xs = s[6];
    endtask : cycle
endmodule : mrio_cpu_model

// ==== testbench.sv ====
`timescale 1ns/1ps

module testbench;
    localparam logic [3:0] ID = 4'h5;
    localparam logic [3:0] DIR = 4'h3;
    localparam logic [3:0] INV = 4'h5;
    localparam logic [3:0] RDV = 4'h2;

    function automatic logic [2047:0] mk_rom();
        for (int i = 0; i < 256; i++) mk_rom[i*8 +: 8] = 8'(i * 37 + 11);
    endfunction : mk_rom

    localparam logic [2047:0] ROM = mk_rom();

    logic clk_i = 1'b0, rst_n = 1'b0, drst_n = 1'b1, clr_n = 1'b1;
    logic [3:0] io_in = 4'h0, dout, doe_n, io_out, io_oe_n, bus;
    logic p1, p2, sy, rs, awr, wr, bv, arr, rv;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] br, rr;
    logic [15:0] lf = 16'h54AA;
    int errors = 0, compares = 0, cyc = 0;

    mrio_top #(.CHIP_ID(ID), .IO_DIR_OUT(DIR), .IO_INV(INV),
        .IO_OUT_RDVAL(RDV), .ROM_IMAGE(ROM)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n), .phase1_n_i(p1), .phase2_n_i(p2),
        .sync_n_i(sy), .rom_command_select_n_i(rs), .dev_reset_n_i(drst_n),
        .port_clear_n_i(clr_n), .data_in_i(bus), .data_out_o(dout),
        .data_oe_n_o(doe_n), .io_in_i(io_in), .io_out_o(io_out),
        .io_oe_n_o(io_oe_n), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bre), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rre), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr));

    mrio_cpu_model cpu (.clk_i(clk_i), .dut_out_i(dout), .dut_oe_n_i(doe_n),
        .ph1_n_o(p1), .ph2_n_o(p2), .sync_n_o(sy), .rsel_n_o(rs),
        .bus_o(bus));

    always #2 clk_i = ~clk_i;

    // ------
    // checking and closing
    // ------
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end

    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nx

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        @(posedge clk_i);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bre <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
        chk("bresp", br, e);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge clk_i);
        arv <= 1'b1; ara <= a; rre <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b0;
        chk("rdata", rd, e);
        chk("rresp", rr, er);
    endtask : axr

    initial begin
        logic [7:0] w, dv, a;
        logic [3:0] xs, lat, v, e;
        lat = 4'h0;
        repeat (10) @(posedge clk_i);
        e = ~INV & DIR;
        chk("rst_io", io_out, e);
        chk("rst_oe", doe_n, 4'hF);
        e = ~DIR;
        chk("io_dir", io_oe_n, e);
        rst_n <= 1'b1;
        axr(8'h00, 32'h1, 2'h0);
        axr(8'h0C, 32'(ID), 2'h0);
        axr(8'h10, 32'h0, 2'h2);
        axw(8'h10, 32'h0, 2'h2);
        @(posedge clk_i);
        cpu.slot(4'h0, 1'b1, 1'b0, 1'b1, xs, dv[0]);
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lf[7:0];
            lf = nx(lf);
            cpu.cycle(a, {1'b1, ID}, 8'h00, 4'h0, 4'h0, w, xs, dv);
            chk("rom_word", w, 8'(a * 37 + 11));
            chk("rom_drv", dv, 8'h18);
        end
        cpu.cycle(8'h12, {1'b0, ID}, 8'h00, 4'h0, 4'h0, w, xs, dv);
        chk("nosel_drv", dv, 8'h00);
        cpu.cycle(8'h12, {1'b1, ID ^ 4'h1}, 8'h00, 4'h0, 4'h0, w, xs, dv);
        chk("other_drv", dv, 8'h00);
        axw(8'h00, 32'h0, 2'h0);
        cpu.cycle(8'h12, {1'b1, ID}, 8'h00, 4'h0, 4'h0, w, xs, dv);
        chk("off_drv", dv, 8'h00);
        axw(8'h00, 32'h1, 2'h0);
        @(posedge clk_i);
        cpu.cycle(8'h00, 5'h00, 8'h00, 4'hB, ID, w, xs, dv);
        for (int i = 0; i < 5; i++) begin
            v = (i == 4) ? 4'hF : lf[3:0];
            lf = nx(lf);
            if (i == 3) begin
                cpu.cycle(8'h00, 5'h00, 8'h00, 4'hB, ID ^ 4'h6, w, xs, dv);
            end
            if (i == 4) cpu.cycle(8'h00, 5'h00, 8'h00, 4'hB, ID, w, xs, dv);
            if (i != 3) lat = v;
            cpu.cycle(8'h00, 5'h00, 8'hE2, 4'hE, v, w, xs, dv);
            e = (lat ^ ~INV) & DIR;
            chk("wr_io", io_out, e);
        end
        e = ~io_in ^ INV;
        axr(8'h08, {20'h00000, (e & ~DIR) | (RDV & DIR), e, lat & DIR},
            2'h0);
        for (int i = 0; i < 3; i++) begin
            io_in <= lf[3:0];
            lf = nx(lf);
            cpu.cycle(8'h00, 5'h00, 8'hEA, 4'hC, 4'h0, w, xs, dv);
            e = ((~io_in ^ INV) & ~DIR) | (RDV & DIR);
            chk("rd_val", xs, e);
            chk("rd_drv", dv, 8'h40);
        end
        clr_n <= 1'b0;
        #1;
        e = ~INV & DIR;
        chk("clr_io", io_out, e);
        @(posedge clk_i);
        clr_n <= 1'b1;
        cpu.cycle(8'h00, 5'h00, 8'hE2, 4'hE, 4'hF, w, xs, dv);
        drst_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("drst_io", io_out, e);
        drst_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        cpu.slot(4'h0, 1'b1, 1'b0, 1'b1, xs, dv[0]);
        cpu.cycle(8'h00, 5'h00, 8'hE2, 4'hE, 4'hF, w, xs, dv);
        chk("drst_sel", io_out, e);
        cpu.cycle(8'h00, 5'h00, 8'h00, 4'hB, ID, w, xs, dv);
        cpu.cycle(8'h00, 5'h00, 8'hEA, 4'hC, 4'h0, w, xs, dv);
        e = ((~io_in ^ INV) & ~DIR) | (RDV & DIR);
        chk("drst_rd", xs, e);
        stop_test();
    end
endmodule : testbench
